// file: adc_power_down_control_regs.vh
`ifndef ADC_POWER_DOWN_CONTROL_REGS_VH
`define ADC_POWER_DOWN_CONTROL_REGS_VH

`define CLK_HZ             10000000
`define WAKEUP_TIME_US     8
`define WAKEUP_CYCLES      ((`WAKEUP_TIME_US * `CLK_HZ) / 1000000)
`define RESULT_BITS        18
`define MAX_SCLKS          5'h18
`define RESULT_RESET       18'h0_0000
`define TIMER_RESET        16'h0000
`define BIT_CNT_RESET      5'h00
`define READY_IDLE         1'b1
`define CONV_PERIOD_CYCLES 1000

`endif

// file: edge_rise_detect.v
`timescale 1ns/10ps
module edge_rise_detect (
    input  wire i_clk_sys,
    input  wire i_clear,
    input  wire i_level,
    output wire o_rise
);
    reg level_q;

    always @(posedge i_clk_sys) begin
        if (i_clear) begin
            level_q <= 1'b0;
        end else begin
            level_q <= i_level;
        end
    end

    assign o_rise = i_level & ~level_q & ~i_clear;
endmodule

// file: adc_power_down_control.v
`timescale 1ns/10ps
`include "adc_power_down_control_regs.vh"

module adc_power_down_control #(
    parameter WAKEUP_CYCLES = `WAKEUP_CYCLES,
    parameter CONV_CYCLES   = `CONV_PERIOD_CYCLES,
    parameter RESULT_BITS   = `RESULT_BITS
) (
    input  wire                   i_clk_sys,
    input  wire                   i_reset_n,
    input  wire                   i_power_down_n,
    input  wire                   i_sclk,
    input  wire [RESULT_BITS-1:0] i_conv_result,
    output reg                    o_ready_and_serial_out,
    output reg                    o_converter_enable,
    output reg                    o_awake
);
    localparam [1:0] ST_DOWN  = 2'b00;
    localparam [1:0] ST_WAKE  = 2'b01;
    localparam [1:0] ST_CONV  = 2'b10;
    localparam [1:0] ST_SHIFT = 2'b11;

    // interval counters start from zero, so each ends one short of its length
    localparam [15:0] WAKE_LAST  = WAKEUP_CYCLES[15:0] - 16'h0001;
    localparam [15:0] CONV_LAST  = CONV_CYCLES[15:0] - 16'h0001;
    localparam [4:0]  DATA_BITS  = RESULT_BITS[4:0];
    localparam [4:0]  SCLK_LIMIT = `MAX_SCLKS;

    // sequencer state and the shared interval counter
    reg [1:0]             state_q;
    reg [1:0]             state_d;
    reg [15:0]            timer_q;
    reg [15:0]            timer_d;

    // readback shift register and count of serial clocks seen
    reg [RESULT_BITS-1:0] shift_q;
    reg [RESULT_BITS-1:0] shift_d;
    reg [4:0]             bit_cnt_q;
    reg [4:0]             bit_cnt_d;

    // next values of the registered outputs
    reg                   serial_out_d;
    reg                   enable_d;
    reg                   awake_d;

    // decoded events of the current cycle
    reg                   wake_done;
    reg                   result_due;
    reg                   shift_clock;
    wire                  sclk_rise;
    wire                  hold_down;

    // true once a zero-based interval counter sits on its last count
    function count_done;
        input [15:0] count;
        input [15:0] last;
        begin
            count_done = (count >= last);
        end
    endfunction

    function [15:0] count_up;
        input [15:0] count;
        begin
            count_up = count + 16'h0001;
        end
    endfunction

    // true while some bits of the loaded result have not left yet
    function bits_left;
        input [4:0] sent;
        begin
            bits_left = (sent < DATA_BITS);
        end
    endfunction

    function [RESULT_BITS-1:0] shift_once;
        input [RESULT_BITS-1:0] word;
        begin
            shift_once = {word[RESULT_BITS-2:0], 1'b0};
        end
    endfunction

    // stops at the limit so a long clock burst cannot wrap the count
    function [4:0] count_clock;
        input [4:0] seen;
        begin
            count_clock = seen;
            if (seen < SCLK_LIMIT) begin
                count_clock = seen + 5'h01;
            end
        end
    endfunction

    // either reset or the power-down pin clears the whole converter core
    assign hold_down = ~i_reset_n | ~i_power_down_n;

    edge_rise_detect u_sclk_edge (
        .i_clk_sys (i_clk_sys),
        .i_clear   (hold_down),
        .i_level   (i_sclk),
        .o_rise    (sclk_rise)
    );

    // the wake-up interval and the conversion period share one counter
    always @* begin
        wake_done   = 1'b0;
        result_due  = 1'b0;
        shift_clock = 1'b0;
        if (state_q == ST_WAKE) begin
            wake_done = count_done(timer_q, WAKE_LAST);
        end
        if (state_q == ST_CONV || state_q == ST_SHIFT) begin
            result_due = count_done(timer_q, CONV_LAST);
        end
        // serial clocks before a result is ready are ignored
        if (state_q == ST_SHIFT) begin
            shift_clock = sclk_rise;
        end
    end

    always @* begin
        state_d = state_q;
        timer_d = count_up(timer_q);
        case (state_q)
            ST_DOWN: begin
                // first cycle after release starts the wake-up interval
                state_d = ST_WAKE;
                timer_d = `TIMER_RESET;
            end
            ST_WAKE: begin
                if (wake_done) begin
                    state_d = ST_CONV;
                    timer_d = `TIMER_RESET;
                end
            end
            ST_CONV: begin
                if (result_due) begin
                    state_d = ST_SHIFT;
                    timer_d = `TIMER_RESET;
                end
            end
            default: begin
                // unread data is overwritten when the next result is due
                if (result_due) begin
                    timer_d = `TIMER_RESET;
                end
            end
        endcase
    end

    // a new result restarts the readback whatever was left unread
    always @* begin
        shift_d   = shift_q;
        bit_cnt_d = bit_cnt_q;
        if (result_due) begin
            shift_d   = i_conv_result;
            bit_cnt_d = `BIT_CNT_RESET;
        end else if (shift_clock) begin
            if (bits_left(bit_cnt_q)) begin
                shift_d = shift_once(shift_q);
            end
            bit_cnt_d = count_clock(bit_cnt_q);
        end
    end

    // ready and data share one pin: low marks a result, then msb first
    always @* begin
        serial_out_d = o_ready_and_serial_out;
        enable_d     = o_converter_enable;
        awake_d      = o_awake;
        if (wake_done) begin
            enable_d = 1'b1;
            awake_d  = 1'b1;
        end
        if (result_due) begin
            serial_out_d = 1'b0;
        end else if (shift_clock) begin
            if (bits_left(bit_cnt_q)) begin
                serial_out_d = shift_q[RESULT_BITS-1];
            end else begin
                // clocks past the last bit force the pin high again
                serial_out_d = `READY_IDLE;
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (hold_down) begin
            state_q <= ST_DOWN;
            timer_q <= `TIMER_RESET;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
        end
    end

    // a readback in progress is dropped with the rest of the core
    always @(posedge i_clk_sys) begin
        if (hold_down) begin
            shift_q   <= `RESULT_RESET;
            bit_cnt_q <= `BIT_CNT_RESET;
        end else begin
            shift_q   <= shift_d;
            bit_cnt_q <= bit_cnt_d;
        end
    end

    always @(posedge i_clk_sys) begin
        if (hold_down) begin
            o_ready_and_serial_out <= `READY_IDLE;
            o_converter_enable     <= 1'b0;
            o_awake                <= 1'b0;
        end else begin
            o_ready_and_serial_out <= serial_out_d;
            o_converter_enable     <= enable_d;
            o_awake                <= awake_d;
        end
    end
endmodule

// file: pdn_monitor.sv
`timescale 1ns/10ps
module pdn_monitor (
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire i_power_down_n,
    input wire o_ready_and_serial_out,
    input wire o_converter_enable);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_dn; !i_power_down_n [*3]; endsequence
    sequence s_wake; !o_converter_enable [*4] ##[1:4] o_converter_enable; endsequence
    a_down_off: assert property (s_dn |-> !o_converter_enable) else $error("on");
    a_down_clr: assert property ($fell(i_power_down_n) |-> ##2
        o_ready_and_serial_out && !o_converter_enable) else $error("kept");
    a_abort_rd: assert property (s_dn |-> o_ready_and_serial_out) else $error("low");
    a_wake_time: assert property ($rose(i_power_down_n) |-> s_wake)
        else $error("wake");
    a_ready_on: assert property ($fell(o_ready_and_serial_out) |->
        o_converter_enable) else $error("off");
endmodule
bind adc_power_down_control pdn_monitor mon_u (
    .i_clk_sys              (i_clk_sys),
    .i_reset_n              (i_reset_n),
    .i_power_down_n         (i_power_down_n),
    .o_ready_and_serial_out (o_ready_and_serial_out),
    .o_converter_enable     (o_converter_enable)
);

// file: host_pin_model.sv
`timescale 1ns/10ps
module host_pin_model (
    output reg o_power_down_n = 1'b0,
    output reg o_sclk         = 1'b0
);
    // pin held low through supply ramp and for at least the minimum pulse
    task pulse_down; o_power_down_n = 0; #30_000 o_power_down_n = 1; endtask
    task shift; o_sclk = 1; #200 o_sclk = 0; #200; endtask
endmodule

// file: adc_power_down_control_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH %0t bad", $time); end end
module adc_power_down_control_test;
    reg i_clk_sys = 0, i_reset_n = 0;
    reg [17:0] i_conv_result = 18'h2_a5c3;
    wire i_power_down_n, i_sclk, o_ready_and_serial_out, o_converter_enable, o_awake;
    int fail_count, n_checks, i;
    always #50 i_clk_sys = ~i_clk_sys;
    adc_power_down_control #(
        .WAKEUP_CYCLES (4)
    ) dut_u (
        .i_clk_sys              (i_clk_sys),
        .i_reset_n              (i_reset_n),
        .i_power_down_n         (i_power_down_n),
        .i_sclk                 (i_sclk),
        .i_conv_result          (i_conv_result),
        .o_ready_and_serial_out (o_ready_and_serial_out),
        .o_converter_enable     (o_converter_enable),
        .o_awake                (o_awake)
    );
    host_pin_model host_u (
        .o_power_down_n (i_power_down_n),
        .o_sclk         (i_sclk)
    );
    task print_verdict;
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_cycle(input int n);
        for (i = 0; i < 400 && !o_converter_enable; i++) #100;
        `CHK(i >= 4 && o_awake, 1'b1)
        for (i = 0; i < 1100 && o_ready_and_serial_out; i++) #100;
        `CHK(o_ready_and_serial_out, 1'b0)
        for (i = 17; i > 17 - n; i--) begin
            host_u.shift();
            `CHK(o_ready_and_serial_out, i < 0 || i_conv_result[i])
        end
    endtask
    task t_abort;
        fork host_u.pulse_down(); join_none
        #300 `CHK({o_ready_and_serial_out, o_converter_enable}, 2'h2)
        i_conv_result = 18'h1_5a3c;
        t_cycle(19);
    endtask
    initial begin
        #1200 i_reset_n = 1;
        host_u.pulse_down();
        t_cycle(5);
        t_abort();
        print_verdict();
    end
    initial begin #1e6; fail_count++; print_verdict(); end
endmodule
